// ===== rtl/bcc_charge_control.v
// What this block does
// - Fast charge allowed requests fast-charge current.
// - Termination zeroes current, then maintenance current.
// - Voltage below low threshold requests precharge.
// - Temperature between zero and limit: precharge.
// - Voltage below precharge voltage requests precharge.
// - Current at request plus margin zeroes request.
// - Over-temperature suspends; clears by hysteresis or 43.0C.
// - Overcharge past limit suspends all charge current.
// - Full flag clears at stored SOC percent.
// - Voltage above charging voltage plus margin suspends.
// - Charging voltage sent and used for checks.
// - Design capacity in mAh or 10 mWh.
// - Learning overwrites last discharge; derives full capacity.
// - Alarm values come from stored parameters.
// - Fixed thresholds taken straight from parameters.
// - Compensated thresholds from cells, voltage, load.
// - Learn only on discharge from near full.
// - Overload current disables discharge.
// - Charge added scaled by efficiency factor.
// - Self-discharge modelled at stored daily rate.
// - Current readings below filter threshold ignored.
// - Resync loads remaining capacity at termination.
// - Compensation bit selects computed or fixed thresholds.
`timescale 1ns/1ps
`include "bcc_defs.vh"

module bcc_charge_control (
   input wire clk,
   input wire reset_n,
   input wire [9:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [9:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg flashReq,
   output reg [7:0] flashIndex,
   input wire [31:0] flashData,
   input wire flashAck,
   input wire [15:0] packVoltage,
   input wire signed [15:0] packCurrent,
   input wire signed [15:0] packTemperature,
   input wire [15:0] senseRaw,
   input wire [7:0] relativeSoc,
   input wire [15:0] remainingCapacity,
   input wire charging,
   input wire fastTerminate,
   input wire [15:0] overchargeMah,
   input wire [15:0] learnedDischarge,
   input wire [15:0] chargeDelta,
   output reg [15:0] chargingCurrent,
   output reg [15:0] chargingVoltage,
   output reg [15:0] designCapacity,
   output reg [15:0] fullChargeCapacity,
   output reg [15:0] remainingTimeAlarm,
   output reg [15:0] remainingCapacityAlarm,
   output reg [15:0] endDischargeThresholdLow,
   output reg [15:0] endDischargeThresholdMid,
   output reg [15:0] endDischargeThresholdHigh,
   output reg chargeSuspended,
   output reg dischargeDisable,
   output reg fullyCharged,
   output reg remainingCapacityLoad,
   output reg [15:0] remainingCapacityValue,
   output reg [15:0] scaledChargeDelta,
   output reg [15:0] dailySelfDischarge,
   output reg signed [15:0] filteredCurrent,
   output reg paramsLoaded
);

   localparam [2:0] ST_LOAD = 3'b001;
   localparam [2:0] ST_WAIT = 3'b010;
   localparam [2:0] ST_RUN = 3'b100;
   localparam [369:0] SLOT_TABLE = `BCC_SLOT_TABLE;

   reg [31:0] paramMem [0:`BCC_NSLOT-1];
   reg [31:0] configQ;
   reg [2:0] stateQ;
   reg [5:0] loadSlotQ;
   reg [9:0] awAddrQ;
   reg awHeldQ;
   reg [31:0] wDataQ;
   reg [3:0] wStrbQ;
   reg wHeldQ;
   reg overTempQ;
   reg overCurrentQ;
   reg terminatedQ;
   reg maintenanceQ;
   reg learnQualQ;
   reg termSeenQ;
   reg [15:0] lmdQ;
   wire [`BCC_NSLOT-1:0] wrHit;
   wire [`BCC_NSLOT-1:0] rdHit;
   wire [31:0] slotMask [0:`BCC_NSLOT-1];
   wire [15:0] compThr [0:2];
   reg [5:0] wrSlot;
   reg [5:0] rdSlot;
   reg wrFound;
   reg rdFound;
   integer i;
   integer k;

   wire running = stateQ[2];
   wire doWrite = awHeldQ && wHeldQ && !s_axi_bvalid;
   wire [7:0] wrIdx = awAddrQ[9:2];
   wire [7:0] rdIdx = s_axi_araddr[9:2];
   wire compEnable = configQ[`BCC_CFG_COMP];
   wire [2:0] cellCount = configQ[`BCC_CFG_CELLS_LO+2:`BCC_CFG_CELLS_LO];

   genvar g;
   generate
      for (g = 0; g < `BCC_NSLOT; g = g + 1) begin : gSlot
         wire [1:0] code = SLOT_TABLE[g*10+8 +: 2];
         assign slotMask[g] = (code == 2'h1) ? 32'h000000FF :
                              (code == 2'h2) ? 32'h0000FFFF : 32'hFFFFFFFF;
         assign wrHit[g] = (wrIdx == SLOT_TABLE[g*10 +: 8]);
         assign rdHit[g] = (rdIdx == SLOT_TABLE[g*10 +: 8]);
      end
   endgenerate

   always @* begin
      wrSlot = 6'h00;
      rdSlot = 6'h00;
      wrFound = 1'b0;
      rdFound = 1'b0;
      for (i = 0; i < `BCC_NSLOT; i = i + 1) begin
         if (wrHit[i]) begin
            wrSlot = i[5:0];
            wrFound = 1'b1;
         end
         if (rdHit[i]) begin
            rdSlot = i[5:0];
            rdFound = 1'b1;
         end
      end
   end

   // Byte-lane merge of a write onto an old word.
   function [31:0] mergeLanes;
      input [31:0] oldWord;
      input [31:0] newWord;
      input [3:0] strb;
      integer b;
      begin
         mergeLanes = oldWord;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               mergeLanes[b*8 +: 8] = newWord[b*8 +: 8];
            end
         end
      end
   endfunction

   wire [15:0] pFast = paramMem[`BCC_S_FASTI][15:0];
   wire [15:0] pMaint = paramMem[`BCC_S_MNTI][15:0];
   wire [15:0] pPreI = paramMem[`BCC_S_PCI][15:0];
   wire [15:0] pPreV = paramMem[`BCC_S_PCV][15:0];
   wire [15:0] pChgV = paramMem[`BCC_S_CHGV][15:0];
   wire [15:0] pMaxT = paramMem[`BCC_S_MAXT][15:0];
   wire [15:0] pDv = paramMem[`BCC_S_DV][15:0];

   // End-of-discharge thresholds: point 0 uses 0%, point 1 uses 3%, point 2 the low-battery %.
   wire [15:0] absCurrent = packCurrent[15] ? (~packCurrent + 16'h0001) : packCurrent;
   wire [15:0] coldness = (packTemperature < $signed(`BCC_TEMP_COLD)) ?
                          (`BCC_TEMP_COLD - packTemperature) : 16'h0000;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gThr
         wire [7:0] capPt = (g == 0) ? 8'h00 : (g == 1) ? `BCC_CAP_MID :
                            paramMem[`BCC_S_LOWP][7:0];
         wire [7:0] capSum = capPt + paramMem[`BCC_S_C1][7:0];
         wire [7:0] capLeft = (capSum > `BCC_PERCENT_FULL) ? 8'h00 :
                              (`BCC_PERCENT_FULL - capSum);
         wire [31:0] fblDrop = (paramMem[`BCC_S_C0][15:0] * capLeft) >> 4;
         wire [31:0] impedance_shape_factor = paramMem[`BCC_S_R0][15:0] +
                           ((paramMem[`BCC_S_R1][15:0] * capLeft) >> 6) +
                           ((paramMem[`BCC_S_T0][15:0] * coldness) >> 12) +
                           ((coldness != 16'h0000) ? {18'h0, paramMem[`BCC_S_TC][7:0], 6'h00} :
                            32'h0);
         wire [31:0] loadDrop = (absCurrent * impedance_shape_factor) >> 10;
         wire [31:0] perCell = {16'h0000, paramMem[`BCC_S_EMF][15:0]};
         wire [31:0] drops = fblDrop + loadDrop;
         wire [31:0] cellV = (drops >= perCell) ? 32'h0 : (perCell - drops);
         wire [31:0] packV = cellV * cellCount;
         assign compThr[g] = (packV > 32'h0000FFFF) ? 16'hFFFF : packV[15:0];
      end
   endgenerate

   wire [15:0] thrLow = compEnable ? compThr[0] : paramMem[`BCC_S_EMF][15:0];
   wire [15:0] thrHigh = compEnable ? compThr[2] : paramMem[`BCC_S_R0][15:0];

   // Charge conditions.
   wire [16:0] ocLimit = chargingCurrent + paramMem[`BCC_S_OCM][15:0];
   wire overCurrentNow = charging && !packCurrent[15] &&
                         ({1'b0, packCurrent} >= ocLimit);
   wire [16:0] ovLimit = pChgV + paramMem[`BCC_S_OVM][15:0];
   wire overVoltage = {1'b0, packVoltage} > ovLimit;
   wire [15:0] hystTenths = paramMem[`BCC_S_HYST][7:0] * 8'h0A;
   wire tempHigh = packTemperature > $signed(pMaxT);
   wire tempCool = (packTemperature <= $signed(pMaxT - hystTenths)) ||
                   (packTemperature <= $signed(`BCC_TEMP_CLEAR));
   wire overcharge = overchargeMah > paramMem[`BCC_S_MOC][15:0];
   wire preTemp = !packTemperature[15] &&
                  (packTemperature < $signed({8'h00, paramMem[`BCC_S_PCT][7:0]}));
   wire preNeeded = (packVoltage < thrLow) || preTemp ||
                    (packVoltage < pPreV);
   wire suspend = overCurrentQ || overTempQ || overVoltage || overcharge || terminatedQ;

   reg [15:0] currentD;
   always @* begin
      if (suspend) begin
         currentD = 16'h0000;
      end else if (preNeeded) begin
         currentD = pPreI;
      end else if (maintenanceQ) begin
         currentD = pMaint;
      end else begin
         currentD = pFast;
      end
   end

   wire [31:0] dcEnergy = (paramMem[`BCC_S_DCAP][15:0] * pDv) / `BCC_ENERGY_DIV;
   wire [31:0] fccEnergy = (lmdQ * pDv) / `BCC_ENERGY_DIV;
   wire [15:0] fccNow = configQ[`BCC_CFG_ENERGY] ? fccEnergy[15:0] : lmdQ;
   wire [23:0] resyncProd = fccNow * ({8'h00, paramMem[`BCC_S_FCT][7:0]} + 16'h0001);
   wire [23:0] effProd = chargeDelta * ({8'h00, paramMem[`BCC_S_EFF][7:0]} + 16'h0001);
   wire [31:0] sdProd = (fccNow * paramMem[`BCC_S_SDR][7:0]) / `BCC_ENERGY_DIV;
   wire [16:0] nearFullPt = (fccNow > paramMem[`BCC_S_NEARF][15:0]) ?
                            (fccNow - paramMem[`BCC_S_NEARF][15:0]) : 17'h0;

   // Register bus slave and flash loader.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (k = 0; k < `BCC_NSLOT; k = k + 1) begin
            paramMem[k] <= 32'h00000000;
         end
         configQ <= `BCC_CFG_RESET;
         stateQ <= ST_LOAD;
         loadSlotQ <= 6'h00;
         flashReq <= 1'b0;
         flashIndex <= 8'h00;
         paramsLoaded <= 1'b0;
         awAddrQ <= 10'h000;
         awHeldQ <= 1'b0;
         wDataQ <= 32'h00000000;
         wStrbQ <= 4'h0;
         wHeldQ <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `BCC_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `BCC_RESP_OKAY;
      end else begin
         s_axi_awready <= !awHeldQ && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !wHeldQ && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awAddrQ <= s_axi_awaddr;
            awHeldQ <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
            wHeldQ <= 1'b1;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `BCC_RESP_OKAY;
            if (wrFound) begin
               paramMem[wrSlot] <= mergeLanes(paramMem[wrSlot], wDataQ, wStrbQ) &
                                   slotMask[wrSlot];
            end else if (wrIdx == `BCC_IDX_CONFIG) begin
               configQ <= mergeLanes(configQ, wDataQ, wStrbQ);
            end else if (wrIdx != `BCC_IDX_STATUS) begin
               s_axi_bresp <= `BCC_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
         end
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `BCC_RESP_OKAY;
            if (rdFound) begin
               s_axi_rdata <= paramMem[rdSlot];
            end else if (rdIdx == `BCC_IDX_CONFIG) begin
               s_axi_rdata <= configQ;
            end else if (rdIdx == `BCC_IDX_STATUS) begin
               s_axi_rdata <= {24'h0, overVoltage, overcharge, maintenanceQ, terminatedQ,
                               overCurrentQ, overTempQ, fullyCharged, paramsLoaded};
            end else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `BCC_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         case (stateQ)
            ST_LOAD: begin
               flashReq <= 1'b1;
               flashIndex <= SLOT_TABLE[loadSlotQ*10 +: 8];
               stateQ <= ST_WAIT;
            end
            ST_WAIT: begin
               if (flashAck) begin
                  flashReq <= 1'b0;
                  paramMem[loadSlotQ] <= flashData & slotMask[loadSlotQ];
                  if (loadSlotQ == `BCC_NSLOT - 1) begin
                     stateQ <= ST_RUN;
                     paramsLoaded <= 1'b1;
                  end else begin
                     loadSlotQ <= loadSlotQ + 6'h01;
                     stateQ <= ST_LOAD;
                  end
               end
            end
            ST_RUN: begin
               stateQ <= ST_RUN;
            end
            default: begin
               stateQ <= ST_LOAD;
            end
         endcase
      end
   end

   // Charge control and capacity bookkeeping, held at reset values until parameters are loaded, except lmdQ, which copies the stored LMD.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chargingCurrent <= 16'h0000;
         chargingVoltage <= 16'h0000;
         designCapacity <= 16'h0000;
         fullChargeCapacity <= 16'h0000;
         remainingTimeAlarm <= 16'h0000;
         remainingCapacityAlarm <= 16'h0000;
         endDischargeThresholdLow <= 16'h0000;
         endDischargeThresholdMid <= 16'h0000;
         endDischargeThresholdHigh <= 16'h0000;
         chargeSuspended <= 1'b0;
         dischargeDisable <= 1'b0;
         fullyCharged <= 1'b0;
         remainingCapacityLoad <= 1'b0;
         remainingCapacityValue <= 16'h0000;
         scaledChargeDelta <= 16'h0000;
         dailySelfDischarge <= 16'h0000;
         filteredCurrent <= 16'sh0000;
         overTempQ <= 1'b0;
         overCurrentQ <= 1'b0;
         terminatedQ <= 1'b0;
         maintenanceQ <= 1'b0;
         learnQualQ <= 1'b0;
         termSeenQ <= 1'b0;
         lmdQ <= 16'h0000;
      end else if (running) begin
         chargingCurrent <= currentD;
         chargingVoltage <= pChgV;
         chargeSuspended <= suspend;
         designCapacity <= configQ[`BCC_CFG_ENERGY] ? dcEnergy[15:0] :
                           paramMem[`BCC_S_DCAP][15:0];
         fullChargeCapacity <= fccNow;
         remainingTimeAlarm <= paramMem[`BCC_S_RTA][15:0];
         remainingCapacityAlarm <= paramMem[`BCC_S_RCA][15:0];
         endDischargeThresholdLow <= thrLow;
         endDischargeThresholdMid <= compEnable ? compThr[1] : paramMem[`BCC_S_C0][15:0];
         endDischargeThresholdHigh <= thrHigh;
         if (tempHigh) begin
            overTempQ <= 1'b1;
         end else if (tempCool) begin
            overTempQ <= 1'b0;
         end
         if (overCurrentNow) begin
            overCurrentQ <= 1'b1;
         end else if (!charging) begin
            overCurrentQ <= 1'b0;
         end
         termSeenQ <= fastTerminate;
         terminatedQ <= fastTerminate;
         if (termSeenQ && !fastTerminate) begin
            maintenanceQ <= 1'b1;
         end else if (relativeSoc <= paramMem[`BCC_S_FCLR][7:0]) begin
            maintenanceQ <= 1'b0;
         end
         if (fastTerminate) begin
            fullyCharged <= 1'b1;
         end else if (relativeSoc <= paramMem[`BCC_S_FCLR][7:0]) begin
            fullyCharged <= 1'b0;
         end
         remainingCapacityLoad <= configQ[`BCC_CFG_RESYNC] && fastTerminate &&
                                  !termSeenQ;
         remainingCapacityValue <= resyncProd[23:8];
         if (packCurrent[15] && ({1'b0, remainingCapacity} >= nearFullPt)) begin
            learnQualQ <= 1'b1;
         end else if (!packCurrent[15]) begin
            learnQualQ <= 1'b0;
         end
         if (learnQualQ && packCurrent[15] && (packVoltage < thrHigh)) begin
            lmdQ <= learnedDischarge;
         end
         dischargeDisable <= packCurrent[15] &&
                             (absCurrent >= paramMem[`BCC_S_OVLD][15:0]);
         scaledChargeDelta <= effProd[23:8];
         dailySelfDischarge <= sdProd[15:0];
         filteredCurrent <= (senseRaw < {8'h00, paramMem[`BCC_S_FILT][7:0]}) ?
                            16'sh0000 : packCurrent;
      end else begin
         lmdQ <= paramMem[`BCC_S_LMD][15:0];
      end
   end

endmodule // bcc_charge_control

// ===== rtl/bcc_defs.vh
`ifndef BCC_DEFS_VH
`define BCC_DEFS_VH

// Slot number of each parameter the logic reads from the parameter store.
`define BCC_S_RTA 6'h00
`define BCC_S_RCA 6'h01
`define BCC_S_DV 6'h02
`define BCC_S_FILT 6'h03
`define BCC_S_SDR 6'h04
`define BCC_S_LOWP 6'h06
`define BCC_S_NEARF 6'h07
`define BCC_S_DCAP 6'h08
`define BCC_S_LMD 6'h09
`define BCC_S_CHGV 6'h0A
`define BCC_S_PCV 6'h0B
`define BCC_S_FASTI 6'h0C
`define BCC_S_MNTI 6'h0D
`define BCC_S_PCI 6'h0E
`define BCC_S_PCT 6'h0F
`define BCC_S_FCT 6'h10
`define BCC_S_FCLR 6'h11
`define BCC_S_MOC 6'h12
`define BCC_S_EFF 6'h13
`define BCC_S_MAXT 6'h14
`define BCC_S_HYST 6'h15
`define BCC_S_OVLD 6'h16
`define BCC_S_OVM 6'h17
`define BCC_S_OCM 6'h18
`define BCC_S_EMF 6'h1C
`define BCC_S_C0 6'h1D
`define BCC_S_R0 6'h1E
`define BCC_S_T0 6'h1F
`define BCC_S_R1 6'h20
`define BCC_S_TC 6'h21
`define BCC_S_C1 6'h22
`define BCC_NSLOT 37

// Width code (1 = 8 bit, 2 = 16 bit, 3 = 32 bit) and printed index, slot 0 in the low bits.
`define BCC_SLOT_TABLE { \
   {2'h3,8'hBC}, {2'h2,8'hBA}, {2'h1,8'h8F}, {2'h1,8'h8E}, {2'h2,8'h8C}, {2'h2,8'h8A}, \
   {2'h2,8'h88}, {2'h2,8'h86}, {2'h2,8'h84}, {2'h2,8'h78}, {2'h2,8'h73}, {2'h2,8'h6E}, \
   {2'h2,8'h5C}, {2'h2,8'h5A}, {2'h2,8'h58}, {2'h1,8'h55}, {2'h2,8'h53}, {2'h1,8'h51}, \
   {2'h2,8'h4E}, {2'h1,8'h47}, {2'h1,8'h46}, {2'h1,8'h43}, {2'h2,8'h41}, {2'h2,8'h3F}, \
   {2'h2,8'h3D}, {2'h2,8'h3B}, {2'h2,8'h39}, {2'h2,8'h35}, {2'h2,8'h31}, {2'h2,8'h2F}, \
   {2'h1,8'h2E}, {2'h1,8'h2D}, {2'h1,8'h2C}, {2'h1,8'h2B}, {2'h2,8'h04}, {2'h2,8'h02}, \
   {2'h2,8'h00} }

// Own control and status registers (word index).
`define BCC_IDX_CONFIG 8'hF0
`define BCC_IDX_STATUS 8'hF1
`define BCC_CFG_COMP 0
`define BCC_CFG_RESYNC 1
`define BCC_CFG_ENERGY 2
`define BCC_CFG_CELLS_LO 4
`define BCC_CFG_RESET 32'h00000030

// Fixed figures.
`define BCC_TEMP_CLEAR 16'h01AE
`define BCC_TEMP_COLD 16'h00E6
`define BCC_CAP_MID 8'h03
`define BCC_PERCENT_FULL 8'h64
`define BCC_ENERGY_DIV 32'h00002710
`define BCC_RESP_OKAY 2'h0
`define BCC_RESP_SLVERR 2'h2

`endif

// ===== tb/bcc_flash_model.sv
`timescale 1ns/1ps
module bcc_flash_model (
   input wire clk,
   input wire reset_n,
   input wire flashReq,
   input wire [7:0] flashIndex,
   input wire slow,
   output logic [31:0] flashData,
   output logic flashAck
);
   logic [3:0] delayCnt_q;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         delayCnt_q <= 4'h0;
         flashAck <= 1'b0;
         flashData <= 32'h00000000;
      end else if (flashReq && !flashAck && delayCnt_q >= (slow ? 4'h5 : 4'h1)) begin
         delayCnt_q <= 4'h0;
         flashAck <= 1'b1;
         flashData <= (flashIndex == 8'h2E) ? 32'h00000005 : {24'h5A5A01, flashIndex};
      end else begin
         delayCnt_q <= (flashReq && !flashAck) ? delayCnt_q + 4'h1 : 4'h0;
         flashAck <= 1'b0;
         flashData <= ~flashData;
      end
   end
endmodule // bcc_flash_model

// ===== tb/bcc_params_chk.sv
`timescale 1ns/1ps
module bcc_params_chk (
   input wire clk,
   input wire reset_n,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire flashReq,
   input wire flashAck,
   input wire [7:0] flashIndex,
   input wire fastTerminate,
   input wire paramsLoaded,
   input wire chargeSuspended,
   input wire remainingCapacityLoad,
   input wire [15:0] chargingCurrent
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_load_gate: assert property (!paramsLoaded |-> chargingCurrent == 16'h0000)
      else $error("Charge current set before load.");
   a_fetch_hold: assert property (flashReq && !flashAck |=> flashReq && $stable(flashIndex))
      else $error("Fetch request dropped early.");
   a_load_done: assert property (paramsLoaded |-> !flashReq)
      else $error("Fetch after load.");
   a_susp_zero: assert property (paramsLoaded && chargeSuspended |-> chargingCurrent == 16'h0000)
      else $error("Current requested while suspended.");
   a_term_zero: assert property (paramsLoaded && fastTerminate |=> ##1 chargingCurrent == 16'h0000)
      else $error("Current requested at termination.");
   a_resync_pulse: assert property (remainingCapacityLoad |=> !remainingCapacityLoad)
      else $error("Capacity load pulse too long.");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read answer late.");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
      else $error("Write answer late.");
   a_bresp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("Write answer held.");
   a_rresp_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("Read answer held.");
endmodule // bcc_params_chk
bind bcc_charge_control bcc_params_chk i_chk (.*);

// ===== tb/test_battery_charge_control_params.sv
`timescale 1ns/1ps
module test_battery_charge_control_params;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
   logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, flashData, q;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slowFlash = 1'b1, rcSeen = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic flashReq, flashAck, charging = 1'b0, fastTerminate = 1'b0;
   logic [7:0] flashIndex, relativeSoc = 8'h64;
   logic [15:0] packVoltage = 16'h01F4, senseRaw = 16'h0000, remainingCapacity = 16'h0000;
   logic signed [15:0] packCurrent = 16'sh0000, packTemperature = 16'sh00FA, filteredCurrent;
   logic [15:0] overchargeMah = 16'h0000, learnedDischarge = 16'h0000, chargeDelta = 16'h0100;
   logic [15:0] chargingCurrent, chargingVoltage, designCapacity, fullChargeCapacity;
   logic [15:0] remainingTimeAlarm, remainingCapacityAlarm, remainingCapacityValue;
   logic [15:0] endDischargeThresholdLow, endDischargeThresholdMid, endDischargeThresholdHigh;
   logic [15:0] scaledChargeDelta, dailySelfDischarge;
   logic chargeSuspended, dischargeDisable, fullyCharged, remainingCapacityLoad, paramsLoaded;
   int errCount = 0, comparisons = 0, cycles = 0;
   bcc_charge_control i_dut (.*);
   bcc_flash_model i_flash (.clk(clk), .reset_n(reset_n), .flashReq(flashReq),
      .flashIndex(flashIndex), .slow(slowFlash), .flashData(flashData), .flashAck(flashAck));
   always #2.5 clk = ~clk;
   task automatic stopTest;
      $display("Comparisons %0d, mismatches %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (remainingCapacityLoad === 1'b1) rcSeen <= 1'b1;
      if (cycles == 20000) begin
         errCount++;
         stopTest;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         errCount++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic axi(input logic wr, input logic [9:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic [1:0] rs);
      logic done;
      done = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
      while (!done) begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if ((wr ? s_axi_bvalid : s_axi_rvalid) === 1'b1) begin
            done = 1'b1;
            rd = s_axi_rdata;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
         end
      end
   endtask
   task automatic drv(input logic [15:0] v, input logic [15:0] t, input logic [15:0] i);
      @(posedge clk);
      packVoltage <= v;
      packTemperature <= t;
      packCurrent <= i;
      repeat (3) @(posedge clk);
   endtask
   task automatic resetDut;
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
   endtask
   task automatic loadScenario;
      repeat (2000) if (paramsLoaded !== 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
      chk("loaded", 32'h1, 32'(paramsLoaded));
      chk("chgVolt", 32'h0139, 32'(chargingVoltage));
      chk("desCap", 32'h0131, 32'(designCapacity));
      chk("fullCap", 32'h0135, 32'(fullChargeCapacity));
      chk("timeAlarm", 32'h0100, 32'(remainingTimeAlarm));
      chk("capAlarm", 32'h0102, 32'(remainingCapacityAlarm));
      chk("thrLow", 32'h0184, 32'(endDischargeThresholdLow));
      chk("thrMid", 32'h0186, 32'(endDischargeThresholdMid));
      chk("thrHigh", 32'h0188, 32'(endDischargeThresholdHigh));
      chk("effScale", 32'h0052, 32'(scaledChargeDelta));
      axi(1'b0, 10'h0F4, 32'h0, q, r);
      chk("fastReg", 32'h013D, q);
      axi(1'b0, 10'h10C, 32'h0, q, r);
      chk("pcTempReg", 32'h43, q);
      axi(1'b0, 10'h240, 32'h0, q, r);
      chk("badResp", 32'h2, 32'(r));
      chk("badData", 32'h0, q);
   endtask
   task automatic selectScenario;
      logic [15:0] v[5] = '{16'd500, 16'd350, 16'd300, 16'd500, 16'd700};
      logic [15:0] t[5] = '{16'd250, 16'd250, 16'd250, 16'd50, 16'd250};
      logic [15:0] e[5] = '{16'h013D, 16'h0141, 16'h0141, 16'h0141, 16'h0000};
      for (int i = 0; i < 5; i++) begin
         if (i == 2) axi(1'b1, 10'h210, 32'h000000C8, q, r);
         drv(v[i], t[i], 16'd0);
         chk("chgCur", 32'(e[i]), 32'(chargingCurrent));
      end
      chk("overVolt", 32'h1, 32'(chargeSuspended));
   endtask
   task automatic tempScenario;
      logic [15:0] t[6] = '{16'd510, 16'd490, 16'd480, 16'd510, 16'd440, 16'd430};
      logic e[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      axi(1'b1, 10'h14C, 32'h000001F4, q, r);
      axi(1'b1, 10'h154, 32'hFFFFFF02, q, r);
      axi(1'b0, 10'h154, 32'h0, q, r);
      chk("hystReg", 32'h2, q);
      for (int i = 0; i < 6; i++) begin
         if (i == 3) axi(1'b1, 10'h154, 32'h0000000A, q, r);
         drv(16'd500, t[i], 16'd0);
         chk("overTemp", 32'(e[i]), 32'(chargeSuspended));
      end
   endtask
   task automatic termScenario;
      axi(1'b1, 10'h3C0, 32'h00000032, q, r);
      fastTerminate <= 1'b1;
      drv(16'd500, 16'd250, 16'd0);
      chk("termCur", 32'h0, 32'(chargingCurrent));
      chk("resync", 32'h1, 32'(rcSeen));
      chk("fullSet", 32'h1, 32'(fullyCharged));
      fastTerminate <= 1'b0;
      drv(16'd500, 16'd250, 16'd0);
      chk("maintCur", 32'h013F, 32'(chargingCurrent));
      relativeSoc <= 8'd72;
      drv(16'd500, 16'd250, 16'd0);
      chk("fullHold", 32'h1, 32'(fullyCharged));
      relativeSoc <= 8'd71;
      drv(16'd500, 16'd250, 16'd0);
      chk("fullClr", 32'h0, 32'(fullyCharged));
   endtask
   task automatic limitScenario;
      drv(16'd500, 16'd250, 16'd664);
      chk("ocBelow", 32'h013D, 32'(chargingCurrent));
      drv(16'd500, 16'd250, 16'd665);
      chk("ocTrip", 32'h0, 32'(chargingCurrent));
      charging <= 1'b0;
      drv(16'd500, 16'd250, 16'hFF9C);
      chk("ovlOff", 32'h0, 32'(dischargeDisable));
      drv(16'd500, 16'd250, 16'hFE70);
      chk("ovlOn", 32'h1, 32'(dischargeDisable));
      charging <= 1'b1;
      overchargeMah <= 16'h014E;
      drv(16'd500, 16'd250, 16'd0);
      chk("ocgAt", 32'h013D, 32'(chargingCurrent));
      overchargeMah <= 16'h014F;
      drv(16'd500, 16'd250, 16'd0);
      chk("ocgPast", 32'h0, 32'(chargingCurrent));
   endtask
   initial begin
      resetDut;
      loadScenario;
      charging <= 1'b1;
      selectScenario;
      tempScenario;
      termScenario;
      limitScenario;
      slowFlash <= 1'b0;
      resetDut;
      loadScenario;
      stopTest;
   end
endmodule // test_battery_charge_control_params
